/* rtl/cpc_contact_logic.sv */
// cascade primary-loop contact, tracking and retransmission logic
//
// Functional notes
// - The four select contacts form a binary pattern number, contact 0 LSB.
// - A new pattern is taken only in reset mode, never while running.
// - A rising run contact starts the program with the selected pattern.
// - A rising stop contact ends the program and outputs the preset value.
// - A rising tracking contact enters local mode.
// - Tracking active selects the tracking input, else the PID result, or the preset value while stopped.
// - Tracking freezes computation and restarts it from the last sample.
// - The tracking input is passed with no bias, filter or computation.
// - Contact outputs one to six carry the six event signals in order.
// - The fail contact is active normally and inactive on failure.
// - Eight PID parameter sets are stored for the computation to select.
// - Retransmission source is PV, setpoint or control output by type.
// - Type four makes the shared terminal loop power, no retransmission.
// - Input path offers bias, square root, lag filter, 11-point linearizer.
// - Run bias and filter in normal use, setup pair for fixed correction.
`timescale 1ns/100ps
`include "cpc_params.svh"
module cpc_contact_logic
  import cpc_pkg::*;
(
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  // register port
  input  wire cpc_bus_t                 bus,
  output logic [`CPC_DW-1:0]            rd_data,
  output logic                          irq,
  // contact inputs
  input  wire logic                     pattern_sel_bit0,
  input  wire logic                     pattern_sel_bit1,
  input  wire logic                     pattern_sel_bit2,
  input  wire logic                     pattern_sel_bit3,
  input  wire logic                     run_contact,
  input  wire logic                     stop_contact,
  input  wire logic                     track_contact,
  // analog values and computation interface
  input  wire logic [`CPC_DW-1:0]       primary_pv_in,
  input  wire logic [`CPC_DW-1:0]       tracking_analog_in,
  input  wire logic [`CPC_DW-1:0]       pid_result,
  input  wire logic [`CPC_DW-1:0]       program_setpoint,
  input  wire logic [`CPC_PID_IDX_W-1:0] pid_set_idx,
  input  wire logic [`CPC_PAT_W-1:0]    lin_idx,
  input  wire cpc_events_t              events_in,
  input  wire logic                     fail_cond,
  output cpc_pid_t                      pid_params,
  output logic                          compute_en,
  output logic                          compute_init,
  output logic [`CPC_DW-1:0]            init_mv,
  output logic [`CPC_DW-1:0]            pv_bias,
  output logic [`CPC_FILT_W-1:0]        pv_filter,
  output logic                          sqrt_en,
  output logic                          lin_en,
  output logic                          lin_bias_mode,
  output logic [`CPC_DW-1:0]            lin_point,
  // outputs
  output logic [`CPC_PAT_W-1:0]         selected_pattern_num,
  output cpc_mode_t                     mode,
  output logic [`CPC_DW-1:0]            manipulated_out,
  output logic [`CPC_DW-1:0]            shared_retrans_terminal,
  output logic                          loop_power_en,
  output logic                          pv_event_one_out,
  output logic                          pv_event_two_out,
  output logic                          instr_alarm_out,
  output logic                          time_event_one_out,
  output logic                          time_event_two_out,
  output logic                          time_event_three_out,
  output logic                          fail_contact_out
);

  // sampled contacts and edges
  logic                   run_q;
  logic                   stop_q;
  logic                   track_q;
  logic                   fail_q;
  logic [`CPC_PAT_W-1:0]  sel_code;
  logic                   run_rise;
  logic                   stop_rise;
  logic                   track_rise;
  logic                   track_fall;
  logic                   fail_rise;

  assign sel_code   = {pattern_sel_bit3, pattern_sel_bit2,
                       pattern_sel_bit1, pattern_sel_bit0};
  assign run_rise   = run_contact & ~run_q;
  assign stop_rise  = stop_contact & ~stop_q;
  assign track_rise = track_contact & ~track_q;
  assign track_fall = ~track_contact & track_q;
  assign fail_rise  = fail_cond & ~fail_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      run_q   <= 1'b0;
      stop_q  <= 1'b0;
      track_q <= 1'b0;
      fail_q  <= 1'b0;
    end else begin
      run_q   <= run_contact;
      stop_q  <= stop_contact;
      track_q <= track_contact;
      fail_q  <= fail_cond;
    end
  end

  // software registers
  logic [`CPC_DW-1:0]    ctrl;
  logic [`CPC_DW-1:0]    preset_val;
  logic [`CPC_DW-1:0]    run_input_bias;
  logic [`CPC_FILT_W-1:0] run_input_filter;
  logic [`CPC_DW-1:0]    setup_input_bias;
  logic [`CPC_FILT_W-1:0] setup_input_filter;
  logic [`CPC_EV_W-1:0]  irq_status;
  logic [`CPC_EV_W-1:0]  irq_mask;
  logic [`CPC_RET_W-1:0] retrans_type_sel;
  cpc_pid_t              pid_mem [`CPC_PID_SETS];
  logic [`CPC_DW-1:0]    lin_mem [`CPC_LIN_POINTS];

  // pid table: three words per set, index = set*4 + field
  logic                       pid_hit;
  logic                       lin_hit;
  logic [`CPC_PID_IDX_W-1:0]  pid_wset;
  logic [1:0]                 pid_wfld;
  logic [`CPC_PAT_W-1:0]      lin_widx;
  logic                       lin_valid;

  assign pid_hit  = bus.addr >= `CPC_A_PID_BASE &&
                    bus.addr <= `CPC_A_PID_TOP;
  assign lin_hit  = bus.addr >= `CPC_A_LIN_BASE &&
                    bus.addr <= `CPC_A_LIN_TOP;
  assign pid_wset = bus.addr[4:2];
  assign pid_wfld = bus.addr[1:0];
  assign lin_widx = bus.addr[5:2];
  assign lin_valid = lin_widx < `CPC_PAT_W'(`CPC_LIN_POINTS);
  assign retrans_type_sel = ctrl[`CPC_C_RET_LSB +: `CPC_RET_W];

  logic [`CPC_EV_W-1:0] ev_set;
  assign ev_set[`CPC_EV_RUN]     = run_rise;
  assign ev_set[`CPC_EV_STOP]    = stop_rise;
  assign ev_set[`CPC_EV_LOCAL]   = track_rise;
  assign ev_set[`CPC_EV_TRK_END] = track_fall;
  assign ev_set[`CPC_EV_FAIL]    = fail_rise;

  logic wr_stat;
  assign wr_stat = bus.wr && bus.addr == `CPC_A_STATUS;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl               <= {`CPC_DW{1'b0}};
      preset_val         <= {`CPC_DW{1'b0}};
      run_input_bias     <= {`CPC_DW{1'b0}};
      run_input_filter   <= {`CPC_FILT_W{1'b0}};
      setup_input_bias   <= {`CPC_DW{1'b0}};
      setup_input_filter <= {`CPC_FILT_W{1'b0}};
      irq_mask           <= {`CPC_EV_W{1'b0}};
    end else if (bus.wr) begin
      unique case (bus.addr)
        `CPC_A_CTRL:     ctrl               <= bus.wdata;
        `CPC_A_PRESET:   preset_val         <= bus.wdata;
        `CPC_A_RUN_BIAS: run_input_bias     <= bus.wdata;
        `CPC_A_RUN_FILT: run_input_filter   <= bus.wdata[`CPC_FILT_W-1:0];
        `CPC_A_SET_BIAS: setup_input_bias   <= bus.wdata;
        `CPC_A_SET_FILT: setup_input_filter <= bus.wdata[`CPC_FILT_W-1:0];
        `CPC_A_IRQ_MASK: irq_mask           <= bus.wdata[`CPC_EV_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky status: a set in the clearing cycle wins
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_status <= {`CPC_EV_W{1'b0}};
    end else begin
      irq_status <= (irq_status &
                     ~(wr_stat ? bus.wdata[`CPC_EV_W-1:0] :
                       {`CPC_EV_W{1'b0}})) | ev_set;
    end
  end
  assign irq = |(irq_status & irq_mask);

  // parameter tables, no reset needed for storage
  always_ff @(posedge ref_clk) begin
    if (bus.wr && pid_hit) begin
      unique case (pid_wfld)
        2'h0:    pid_mem[pid_wset].p <= bus.wdata;
        2'h1:    pid_mem[pid_wset].i <= bus.wdata;
        2'h2:    pid_mem[pid_wset].d <= bus.wdata;
        default: ;
      endcase
    end
    if (bus.wr && lin_hit && lin_valid) begin
      lin_mem[lin_widx] <= bus.wdata;
    end
  end

  assign pid_params = pid_mem[pid_set_idx];
  assign lin_point  = (lin_idx < `CPC_PAT_W'(`CPC_LIN_POINTS)) ?
                      lin_mem[lin_idx] : {`CPC_DW{1'b0}};

  // input path configuration
  assign sqrt_en       = ctrl[`CPC_C_SQRT];
  assign lin_en        = ctrl[`CPC_C_LIN_EN];
  assign lin_bias_mode = ctrl[`CPC_C_LIN_BIAS];
  assign pv_bias   = ctrl[`CPC_C_SETUP] ? setup_input_bias :
                     run_input_bias;
  assign pv_filter = ctrl[`CPC_C_SETUP] ? setup_input_filter :
                     run_input_filter;

  // operating mode
  cpc_mode_t next_mode;
  always_comb begin
    next_mode = mode;
    unique case (mode)
      CPC_RESET: begin
        if (track_rise) next_mode = CPC_LOCAL;
        else if (run_rise) next_mode = CPC_PROGRAM;
      end
      CPC_PROGRAM: begin
        if (stop_rise) next_mode = CPC_RESET;
        else if (track_rise) next_mode = CPC_LOCAL;
      end
      CPC_LOCAL: begin
        if (stop_rise) next_mode = CPC_RESET;
        else if (run_rise) next_mode = CPC_PROGRAM;
      end
      default: next_mode = CPC_RESET;
    endcase
  end

  logic                  pat_take;
  assign pat_take = (mode == CPC_RESET) && !run_rise &&
                    sel_code != `CPC_PAT_NONE;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mode                 <= CPC_RESET;
      selected_pattern_num <= `CPC_PAT_RESET;
    end else begin
      mode <= next_mode;
      if (pat_take) selected_pattern_num <= sel_code;
    end
  end

  // tracking and manipulated output
  logic [`CPC_DW-1:0] track_hold;
  logic               stopped;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      track_hold      <= {`CPC_DW{1'b0}};
      manipulated_out <= {`CPC_DW{1'b0}};
      compute_init    <= 1'b0;
      stopped         <= 1'b1;
    end else begin
      if (track_contact) track_hold <= tracking_analog_in;
      compute_init <= track_fall;
      if (stop_rise) stopped <= 1'b1;
      else if (run_rise || track_rise) stopped <= 1'b0;
      if (track_contact) manipulated_out <= tracking_analog_in;
      else if (stop_rise || (stopped && !run_rise))
        manipulated_out <= preset_val;
      else manipulated_out <= pid_result;
    end
  end
  assign compute_en = ~track_contact & ~stopped;
  assign init_mv    = track_hold;

  // retransmission and loop power
  logic [`CPC_DW-1:0] next_retrans;
  always_comb begin
    unique case (retrans_type_sel)
      `CPC_RET_PV:  next_retrans = primary_pv_in;
      `CPC_RET_SP:  next_retrans = program_setpoint;
      `CPC_RET_OUT: next_retrans = manipulated_out;
      default:      next_retrans = {`CPC_DW{1'b0}};
    endcase
  end

  // contact outputs
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      shared_retrans_terminal <= {`CPC_DW{1'b0}};
      loop_power_en           <= 1'b0;
      pv_event_one_out        <= 1'b0;
      pv_event_two_out        <= 1'b0;
      instr_alarm_out         <= 1'b0;
      time_event_one_out      <= 1'b0;
      time_event_two_out      <= 1'b0;
      time_event_three_out    <= 1'b0;
      fail_contact_out        <= 1'b0;
    end else begin
      shared_retrans_terminal <= next_retrans;
      loop_power_en   <= retrans_type_sel == `CPC_RET_LOOP_PWR;
      pv_event_one_out     <= events_in.pv_event_one;
      pv_event_two_out     <= events_in.pv_event_two;
      instr_alarm_out      <= events_in.instr_alarm;
      time_event_one_out   <= events_in.time_event_one;
      time_event_two_out   <= events_in.time_event_two;
      time_event_three_out <= events_in.time_event_three;
      fail_contact_out     <= ~fail_cond;
    end
  end

  // register read, one cycle later
  logic [`CPC_DW-1:0] rd_mux;
  always_comb begin
    rd_mux = {`CPC_DW{1'b0}};
    if (pid_hit) begin
      unique case (pid_wfld)
        2'h0:    rd_mux = pid_mem[pid_wset].p;
        2'h1:    rd_mux = pid_mem[pid_wset].i;
        2'h2:    rd_mux = pid_mem[pid_wset].d;
        default: rd_mux = {`CPC_DW{1'b0}};
      endcase
    end else if (lin_hit) begin
      if (lin_valid) rd_mux = lin_mem[lin_widx];
    end else begin
      unique case (bus.addr)
        `CPC_A_STATUS:   rd_mux = `CPC_DW'(irq_status);
        `CPC_A_IRQ_MASK: rd_mux = `CPC_DW'(irq_mask);
        `CPC_A_CTRL:     rd_mux = ctrl;
        `CPC_A_PRESET:   rd_mux = preset_val;
        `CPC_A_RUN_BIAS: rd_mux = run_input_bias;
        `CPC_A_RUN_FILT: rd_mux = `CPC_DW'(run_input_filter);
        `CPC_A_SET_BIAS: rd_mux = setup_input_bias;
        `CPC_A_SET_FILT: rd_mux = `CPC_DW'(setup_input_filter);
        `CPC_A_MODE:     rd_mux = {8'h00, selected_pattern_num, 2'h0,
                                   mode};
        `CPC_A_HOLD:     rd_mux = track_hold;
        default:         rd_mux = {`CPC_DW{1'b0}};
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) rd_data <= {`CPC_DW{1'b0}};
    else if (bus.rd) rd_data <= rd_mux;
    else rd_data <= {`CPC_DW{1'b0}};
  end

endmodule : cpc_contact_logic

/* rtl/cpc_params.svh */
// constants of the cascade primary-loop contact logic
`ifndef CPC_PARAMS_SVH
`define CPC_PARAMS_SVH
`define CPC_DW            16
`define CPC_PAT_W         4
`define CPC_PAT_RESET     4'h1
`define CPC_PAT_NONE      4'h0
`define CPC_PID_SETS      8
`define CPC_PID_IDX_W     3
`define CPC_RET_W         3
`define CPC_RET_OFF       3'h0
`define CPC_RET_PV        3'h1
`define CPC_RET_SP        3'h2
`define CPC_RET_OUT       3'h3
`define CPC_RET_LOOP_PWR  3'h4
`define CPC_LIN_POINTS    11
`define CPC_ADDR_W        8
`define CPC_A_STATUS      8'h00
`define CPC_A_IRQ_MASK    8'h04
`define CPC_A_CTRL        8'h08
`define CPC_A_PRESET      8'h0C
`define CPC_A_RUN_BIAS    8'h10
`define CPC_A_RUN_FILT    8'h14
`define CPC_A_SET_BIAS    8'h18
`define CPC_A_SET_FILT    8'h1C
`define CPC_A_MODE        8'h20
`define CPC_A_HOLD        8'h24
`define CPC_A_PID_BASE    8'h40
`define CPC_A_LIN_BASE    8'h80
`define CPC_A_PID_TOP     8'h5F
`define CPC_A_LIN_TOP     8'hAF
`define CPC_FILT_W        4
`define CPC_EV_W          5
`define CPC_EV_RUN        0
`define CPC_EV_STOP       1
`define CPC_EV_LOCAL      2
`define CPC_EV_TRK_END    3
`define CPC_EV_FAIL       4
`define CPC_CTRL_RESET    8'h00
`define CPC_C_SQRT        0
`define CPC_C_LIN_EN      1
`define CPC_C_LIN_BIAS    2
`define CPC_C_SETUP       3
`define CPC_C_RET_LSB     4
`endif

/* rtl/cpc_pkg.sv */
// types of the cascade primary-loop contact logic
`include "cpc_params.svh"
package cpc_pkg;
  typedef enum logic [1:0] {CPC_RESET, CPC_PROGRAM, CPC_LOCAL} cpc_mode_t;
  typedef struct packed {
    logic [`CPC_DW-1:0] p;
    logic [`CPC_DW-1:0] i;
    logic [`CPC_DW-1:0] d;
  } cpc_pid_t;
  typedef struct packed {
    logic pv_event_one;
    logic pv_event_two;
    logic instr_alarm;
    logic time_event_one;
    logic time_event_two;
    logic time_event_three;
  } cpc_events_t;
  typedef struct packed {
    logic [`CPC_ADDR_W-1:0] addr;
    logic [`CPC_DW-1:0]     wdata;
    logic                   wr;
    logic                   rd;
  } cpc_bus_t;
endpackage : cpc_pkg

/* verif/cpc_contact_logic_assertions.sv */
// checker bound to the contact logic ports
`timescale 1ns/100ps
`include "cpc_params.svh"
module cpc_contact_logic_checker
  import cpc_pkg::*;
(
  // clock and reset
  input wire logic                  ref_clk,
  input wire logic                  srst,
  // contacts and analog
  input wire logic                  pattern_sel_bit0,
  input wire logic                  pattern_sel_bit1,
  input wire logic                  pattern_sel_bit2,
  input wire logic                  pattern_sel_bit3,
  input wire logic                  run_contact,
  input wire logic                  stop_contact,
  input wire logic                  track_contact,
  input wire logic [`CPC_DW-1:0]    tracking_analog_in,
  input wire cpc_events_t           events_in,
  input wire logic                  fail_cond,
  // outputs
  input wire logic                  compute_init,
  input wire logic [`CPC_DW-1:0]    init_mv,
  input wire logic [`CPC_PAT_W-1:0] selected_pattern_num,
  input wire cpc_mode_t             mode,
  input wire logic [`CPC_DW-1:0]    manipulated_out,
  input wire logic                  pv_event_one_out,
  input wire logic                  pv_event_two_out,
  input wire logic                  instr_alarm_out,
  input wire logic                  time_event_one_out,
  input wire logic                  time_event_two_out,
  input wire logic                  time_event_three_out,
  input wire logic                  fail_contact_out
);
  logic [3:0] sel;
  assign sel = {pattern_sel_bit3, pattern_sel_bit2,
                pattern_sel_bit1, pattern_sel_bit0};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_run_rise;
    run_contact && !$past(run_contact);
  endsequence
  sequence s_release;
    !$past(srst) && $fell(track_contact);
  endsequence
  property p_track; track_contact |=>
    manipulated_out == $past(tracking_analog_in); endproperty
  property p_events; 1'b1 |=> {pv_event_one_out, pv_event_two_out,
    instr_alarm_out, time_event_one_out, time_event_two_out,
    time_event_three_out} == $past(events_in); endproperty
  property p_fail; 1'b1 |=> fail_contact_out == !$past(fail_cond);
  endproperty
  property p_take; mode == CPC_RESET && !run_contact && !track_contact
    && sel != 4'h0 |=> selected_pattern_num == $past(sel); endproperty
  property p_hold; mode != CPC_RESET || sel == 4'h0 |=>
    $stable(selected_pattern_num); endproperty
  property p_run; s_run_rise ##0 (mode == CPC_RESET && !track_contact
    && !stop_contact) |=> mode == CPC_PROGRAM; endproperty
  property p_stop; mode == CPC_PROGRAM && stop_contact &&
    !$past(stop_contact) |=> mode == CPC_RESET; endproperty
  property p_local; track_contact && !$past(track_contact) &&
    !stop_contact && !run_contact |=> mode == CPC_LOCAL; endproperty
  property p_resume; s_release |=> compute_init &&
    init_mv == $past(tracking_analog_in, 2); endproperty
  a_track: assert property (p_track) else $error("mv not tracking");
  a_events: assert property (p_events) else $error("event out");
  a_fail: assert property (p_fail) else $error("fail contact");
  a_take: assert property (p_take) else $error("pattern not taken");
  a_hold: assert property (p_hold) else $error("pattern changed");
  a_run: assert property (p_run) else $error("run not started");
  a_stop: assert property (p_stop) else $error("stop ignored");
  a_local: assert property (p_local) else $error("no local mode");
  a_resume: assert property (p_resume) else $error("bad resume");
endmodule : cpc_contact_logic_checker

bind cpc_contact_logic cpc_contact_logic_checker u_chk (.ref_clk, .srst,
  .pattern_sel_bit0, .pattern_sel_bit1, .pattern_sel_bit2,
  .pattern_sel_bit3, .run_contact, .stop_contact, .track_contact,
  .tracking_analog_in, .events_in, .fail_cond, .compute_init, .init_mv,
  .selected_pattern_num, .mode, .manipulated_out, .pv_event_one_out,
  .pv_event_two_out, .instr_alarm_out, .time_event_one_out,
  .time_event_two_out, .time_event_three_out, .fail_contact_out);

/* verif/cpc_secondary_model.sv */
// secondary-loop controller model: tracking contact and analog
`timescale 1ns/100ps
module cpc_secondary_model (
  // clock and reset
  input wire logic   ref_clk,
  input wire logic   srst,
  // cascade request
  input wire logic   cascade_cmd,
  // toward the primary
  output logic        track_contact,
  output logic [15:0] tracking_analog_in
);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      track_contact      <= 1'b0;
      tracking_analog_in <= 16'hACE1;
    end else begin
      track_contact      <= !cascade_cmd;
      tracking_analog_in <= tracking_analog_in + 16'h0137;
    end
  end
endmodule : cpc_secondary_model

/* verif/tb.sv */
// self-checking bench of the contact logic
`timescale 1ns/100ps
module tb;
  import cpc_pkg::*;
`define CHK(a, e) begin \
  num_checks++; \
  if ((a) !== (e)) begin \
    n_mismatch++; \
    $display("wrong value at %0t: %h vs %h", $time, a, e); \
  end \
end
  logic ref_clk = 1'b0, srst = 1'b1, run = 1'b0, stp = 1'b0;
  logic cascade = 1'b1, fail = 1'b0, rd_seen = 1'b0;
  cpc_bus_t bus = '0;
  cpc_events_t ev = '0;
  logic [3:0] sel = 4'h0, lidx = 4'h0, pv_filter, pat;
  logic [2:0] pidx = 3'h0;
  logic [15:0] pv = '0, sp = '0, pid = '0, seed = 16'h0026, mv, ex;
  logic [15:0] rd_data, init_mv, pv_bias, lin_point, mo, rt, tav, last_trk;
  logic [15:0] exp_q[$];
  cpc_pid_t pid_params;
  cpc_mode_t mode;
  logic irq, ce, ci, sqrt_en, lin_en, lbm, lpe, trk, dfail;
  logic [5:0] dout;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  always #25 ref_clk = ~ref_clk;
  cpc_secondary_model u_sec (.ref_clk, .srst, .cascade_cmd(cascade),
    .track_contact(trk), .tracking_analog_in(tav));
  cpc_contact_logic u_dut (.ref_clk, .srst, .bus, .rd_data, .irq,
    .pattern_sel_bit0(sel[0]), .pattern_sel_bit1(sel[1]),
    .pattern_sel_bit2(sel[2]), .pattern_sel_bit3(sel[3]),
    .run_contact(run), .stop_contact(stp), .track_contact(trk),
    .primary_pv_in(pv), .tracking_analog_in(tav), .pid_result(pid),
    .program_setpoint(sp), .pid_set_idx(pidx), .lin_idx(lidx),
    .events_in(ev), .fail_cond(fail), .pid_params, .compute_en(ce),
    .compute_init(ci), .init_mv, .pv_bias, .pv_filter, .sqrt_en, .lin_en,
    .lin_bias_mode(lbm), .lin_point, .selected_pattern_num(pat), .mode,
    .manipulated_out(mo), .shared_retrans_terminal(rt),
    .loop_power_en(lpe), .pv_event_one_out(dout[5]),
    .pv_event_two_out(dout[4]), .instr_alarm_out(dout[3]),
    .time_event_one_out(dout[2]), .time_event_two_out(dout[1]),
    .time_event_three_out(dout[0]), .fail_contact_out(dfail));
  function logic [15:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction : rnd
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    exp_q.push_back(e);
    @(posedge ref_clk);
    bus <= '0;
  endtask : rd
  // read results arrive the cycle after the strobe
  always @(posedge ref_clk) begin
    rd_seen <= bus.rd;
    if (trk) last_trk <= tav;
    if (rd_seen) begin
      ex = exp_q.pop_front();
      `CHK(rd_data, ex)
    end
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    tick(5);
    srst <= 1'b0;
    @(negedge ref_clk);
    `CHK(pat, 4'h1)
    `CHK(mode, CPC_RESET)
    rd(8'h08, 16'h0000);
    rd(8'h30, 16'h0000);
    $display("test reset done");
    for (int p = 1; p < 16; p++) begin
      @(posedge ref_clk);
      sel <= 4'(p);
      tick(2);
      @(negedge ref_clk);
      `CHK(pat, 4'(p))
    end
    @(posedge ref_clk);
    sel <= 4'h0;
    tick(2);
    @(negedge ref_clk);
    `CHK(pat, 4'hF)
    rd(8'h20, {8'h00, 4'hF, 2'b00, CPC_RESET});
    $display("test pattern done");
    @(posedge ref_clk);
    sel <= 4'h3;
    run <= 1'b1;
    tick(2);
    @(negedge ref_clk);
    `CHK(mode, CPC_PROGRAM)
    `CHK(pat, 4'hF)
    rd(8'h00, 16'h0001);
    wr(8'h04, 16'h0001);
    @(negedge ref_clk);
    `CHK(irq, 1'b1)
    wr(8'h04, 16'h0000);
    @(negedge ref_clk);
    `CHK(irq, 1'b0)
    wr(8'h04, 16'h0001);
    wr(8'h00, 16'h0001);
    @(negedge ref_clk);
    `CHK(irq, 1'b0)
    rd(8'h00, 16'h0000);
    @(posedge ref_clk);
    sel <= 4'h6;
    run <= 1'b0;
    tick(2);
    `CHK(pat, 4'hF)
    $display("test run done");
    wr(8'h0C, 16'h5A3C);
    @(posedge ref_clk);
    pid <= rnd();
    stp <= 1'b1;
    tick(2);
    @(negedge ref_clk);
    `CHK(mode, CPC_RESET)
    `CHK(mo, 16'h5A3C)
    @(posedge ref_clk);
    stp <= 1'b0;
    run <= 1'b1;
    tick(2);
    @(negedge ref_clk);
    `CHK(mode, CPC_PROGRAM)
    `CHK(mo, pid)
    $display("test stop done");
    @(posedge ref_clk);
    cascade <= 1'b0;
    tick(4);
    @(negedge ref_clk);
    `CHK(mode, CPC_LOCAL)
    `CHK(ce, 1'b0)
    @(posedge ref_clk);
    mv = tav;
    @(negedge ref_clk);
    `CHK(mo, mv)
    @(posedge ref_clk);
    cascade <= 1'b1;
    for (int i = 0; i < 6 && ci !== 1'b1; i++) @(negedge ref_clk);
    `CHK(ci, 1'b1)
    `CHK(init_mv, last_trk)
    tick(2);
    @(negedge ref_clk);
    `CHK(mo, pid)
    `CHK(ce, 1'b1)
    $display("test tracking done");
    pv <= rnd();
    sp <= rnd();
    for (int t = 0; t < 5; t++) begin
      wr(8'h08, {9'h000, 3'(t), 4'h0});
      tick(2);
      @(negedge ref_clk);
      `CHK(rt, t == 1 ? pv : t == 2 ? sp : t == 3 ? pid : 16'h0000)
      `CHK(lpe, t == 4)
    end
    wr(8'h10, 16'h1111);
    wr(8'h18, 16'h2222);
    wr(8'h14, 16'h0003);
    wr(8'h1C, 16'h0009);
    wr(8'h08, 16'h0007);
    @(negedge ref_clk);
    `CHK({sqrt_en, lin_en, lbm}, 3'b111)
    `CHK({pv_bias, pv_filter}, {16'h1111, 4'h3})
    wr(8'h08, 16'h0008);
    @(negedge ref_clk);
    `CHK({pv_bias, pv_filter}, {16'h2222, 4'h9})
    wr(8'hA8, 16'hBEEF);
    lidx <= 4'hA;
    @(negedge ref_clk);
    `CHK(lin_point, 16'hBEEF)
    @(posedge ref_clk);
    lidx <= 4'hB;
    @(negedge ref_clk);
    `CHK(lin_point, 16'h0000)
    $display("test retransmission done");
    for (int s = 0; s < 8; s++)
      for (int f = 0; f < 3; f++) wr(8'(64 + 4 * s + f), {4'(f), 12'(s)});
    wr(8'h43, 16'hFFFF);
    for (int s = 0; s < 8; s++) begin
      @(posedge ref_clk);
      pidx <= 3'(s);
      @(negedge ref_clk);
      `CHK(pid_params, {4'h0, 12'(s), 4'h1, 12'(s), 4'h2, 12'(s)})
    end
    $display("test pid done");
    repeat (8) begin
      @(posedge ref_clk);
      mv = rnd();
      {ev, fail} <= mv[6:0];
      @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK(dout, ev)
      `CHK(dfail, !fail)
    end
    $display("test contacts done");
    wrap_up();
  end
endmodule : tb
